// ### verilog/wtbm_top.v
`include "wtbm_map.vh"

module wtbm_top
#(
   parameter TB_DIV = `WTBM_TB_DIV,
   parameter SLEEP_TICKS = `WTBM_SLEEP_TICKS
)
(
   // Clock and reset
   input wire sys_clk,
   input wire reset_n,
   // Register port
   input wire [6:0] reg_addr,
   input wire reg_we,
   input wire [7:0] reg_wdata,
   output reg [7:0] reg_rdata,
   // Operating state and converter pins
   input wire sleep_mode,
   input wire [4:0] supply_code_pin,
   // Block outputs
   output reg wakeup_event,
   output reg low_duty_on_duration,
   output reg low_battery_irq
);

   localparam [3:0] UNIT_SHIFT = `WTBM_UNIT_SHIFT;

   wire tick;
   reg [7:0] exp_reg;
   reg [7:0] period_hi_reg;
   reg [7:0] period_lo_reg;
   reg [7:0] on_time_reg;
   reg [4:0] thresh_reg;
   reg [4:0] level_reg;
   reg [15:0] count_reg;
   reg [7:0] on_left_reg;
   reg [12:0] unit_reg;
   reg [15:0] sleep_cnt_reg;
   reg [4:0] sync1_reg;
   reg [4:0] sync2_reg;
   reg [4:0] sync3_reg;
   wire [15:0] mantissa;
   wire [2:0] exp_r;
   wire [1:0] exp_d;
   wire [3:0] unit_shift;
   wire [12:0] unit_len;
   wire unit_done;
   wire period_end;
   wire code_stable;
   wire sleep_last;
   wire sleep_sample;

   wtbm_prescale #(.DIV(TB_DIV)) wtbm_prescale_inst
   (
      .sys_clk(sys_clk),
      .reset_n(reset_n),
      .tick(tick)
   );

   assign mantissa = {period_hi_reg, period_lo_reg};
   assign exp_r = exp_reg[`WTBM_R_MSB:`WTBM_R_LSB];
   assign exp_d = exp_reg[`WTBM_D_MSB:`WTBM_D_LSB];
   // One unit is 32*2^(R-D) timebase ticks; D never exceeds 3 so the
   // shift stays positive, and R=7 with D=0 needs all thirteen bits.
   assign unit_shift = UNIT_SHIFT + {1'h0, exp_r} - {2'h0, exp_d};
   assign unit_len = 13'h0001 << unit_shift;
   assign unit_done = tick && (unit_reg == unit_len - 13'h0001);
   assign period_end = unit_done && (mantissa != 16'h0000) &&
      (count_reg == 16'h0001);

   // Register writes.
   always @(posedge sys_clk)
   begin
      if (!reset_n)
      begin
         exp_reg <= 8'h00;
         period_hi_reg <= `WTBM_PERIOD_HI_RST;
         period_lo_reg <= `WTBM_PERIOD_LO_RST;
         on_time_reg <= 8'h00;
         thresh_reg <= `WTBM_THRESH_RST;
      end
      else if (reg_we)
      begin
         case (reg_addr)
            `WTBM_ADDR_PERIOD_EXP: exp_reg <= {2'h0, reg_wdata[5:0]};
            `WTBM_ADDR_PERIOD_HI: period_hi_reg <= reg_wdata;
            `WTBM_ADDR_PERIOD_LO: period_lo_reg <= reg_wdata;
            `WTBM_ADDR_ON_TIME: on_time_reg <= reg_wdata;
            `WTBM_ADDR_THRESH: thresh_reg <= reg_wdata[4:0];
            default: exp_reg <= exp_reg;
         endcase
      end
   end

   // Register reads; reserved bits and unmapped addresses read zero.
   always @(posedge sys_clk)
   begin
      if (!reset_n)
         reg_rdata <= 8'h00;
      else
      begin
         case (reg_addr)
            `WTBM_ADDR_PERIOD_EXP: reg_rdata <= exp_reg;
            `WTBM_ADDR_PERIOD_HI: reg_rdata <= period_hi_reg;
            `WTBM_ADDR_PERIOD_LO: reg_rdata <= period_lo_reg;
            `WTBM_ADDR_COUNT_HI: reg_rdata <= count_reg[15:8];
            `WTBM_ADDR_COUNT_LO: reg_rdata <= count_reg[7:0];
            `WTBM_ADDR_ON_TIME: reg_rdata <= on_time_reg;
            `WTBM_ADDR_THRESH: reg_rdata <= {3'h0, thresh_reg};
            `WTBM_ADDR_LEVEL: reg_rdata <= {3'h0, level_reg};
            default: reg_rdata <= 8'h00;
         endcase
      end
   end

   // Unit counter; it runs free and no register write clears it, so a new R or D changes the length of the unit
   // already in progress, which runs on until the counter wraps if it is already past the new end.
   always @(posedge sys_clk)
   begin
      if (!reset_n)
         unit_reg <= 13'h0000;
      else if (tick)
      begin
         if (unit_done)
            unit_reg <= 13'h0000;
         else
            unit_reg <= unit_reg + 13'h0001;
      end
   end

   // Wake-up count and its event pulse.
   always @(posedge sys_clk)
   begin
      if (!reset_n)
      begin
         count_reg <= 16'h0000;
         wakeup_event <= 1'h0;
      end
      else
      begin
         wakeup_event <= period_end;
         // A zero mantissa parks the timer instead of firing every unit.
         if (mantissa == 16'h0000)
            count_reg <= 16'h0000;
         else if (unit_done && count_reg <= 16'h0001)
            count_reg <= mantissa;
         else if (unit_done)
            count_reg <= count_reg - 16'h0001;
      end
   end

   // Low-duty on-time counts the same units as the period, so it follows
   // any change of R and D without a setting of its own.
   always @(posedge sys_clk)
   begin
      if (!reset_n)
      begin
         on_left_reg <= 8'h00;
         low_duty_on_duration <= 1'h0;
      end
      else if (period_end)
      begin
         on_left_reg <= on_time_reg;
         low_duty_on_duration <= (on_time_reg != 8'h00);
      end
      else if (unit_done && on_left_reg != 8'h00)
      begin
         on_left_reg <= on_left_reg - 8'h01;
         if (on_left_reg == 8'h01)
            low_duty_on_duration <= 1'h0;
      end
   end

   // The supply code arrives from the converter outside this clock domain.
   // Each bit passes three flops, and a code is taken only once stages two
   // and three agree, so a code caught in mid-change is never used.
   genvar sync_idx;
   generate
      for (sync_idx = 0; sync_idx < 5; sync_idx = sync_idx + 1)
      begin : g_sync
         always @(posedge sys_clk)
         begin
            if (!reset_n)
            begin
               sync1_reg[sync_idx] <= 1'h0;
               sync2_reg[sync_idx] <= 1'h0;
               sync3_reg[sync_idx] <= 1'h0;
            end
            else
            begin
               sync1_reg[sync_idx] <= supply_code_pin[sync_idx];
               sync2_reg[sync_idx] <= sync1_reg[sync_idx];
               sync3_reg[sync_idx] <= sync2_reg[sync_idx];
            end
         end
      end
   endgenerate

   assign code_stable = (sync2_reg == sync3_reg);
   assign sleep_last = (sleep_cnt_reg == SLEEP_TICKS[15:0] - 16'h0001);
   assign sleep_sample = tick && sleep_last;

   // Sleep refresh counter; it restarts each time the device enters sleep.
   always @(posedge sys_clk)
   begin
      if (!reset_n || !sleep_mode)
         sleep_cnt_reg <= 16'h0000;
      else if (sleep_sample)
         sleep_cnt_reg <= 16'h0000;
      else if (tick)
         sleep_cnt_reg <= sleep_cnt_reg + 16'h0001;
   end

   // Measured level and the low-supply flag, which is a plain level.
   always @(posedge sys_clk)
   begin
      if (!reset_n)
      begin
         level_reg <= 5'h1f;
         low_battery_irq <= 1'h0;
      end
      else
      begin
         if (code_stable && (!sleep_mode || sleep_sample))
            level_reg <= sync3_reg;
         low_battery_irq <= (level_reg < thresh_reg);
      end
   end

endmodule

// ### inc/wtbm_map.vh
`ifndef WTBM_MAP_VH
`define WTBM_MAP_VH
`define WTBM_ADDR_PERIOD_EXP 7'h14
`define WTBM_ADDR_PERIOD_HI 7'h15
`define WTBM_ADDR_PERIOD_LO 7'h16
`define WTBM_ADDR_COUNT_HI 7'h17
`define WTBM_ADDR_COUNT_LO 7'h18
`define WTBM_ADDR_ON_TIME 7'h19
`define WTBM_ADDR_THRESH 7'h1a
`define WTBM_ADDR_LEVEL 7'h1b
`define WTBM_R_MSB 5
`define WTBM_R_LSB 3
`define WTBM_D_MSB 1
`define WTBM_D_LSB 0
`define WTBM_PERIOD_HI_RST 8'h00
`define WTBM_PERIOD_LO_RST 8'h00
`define WTBM_THRESH_RST 5'h14
`define WTBM_CLK_HZ 125000000
`define WTBM_TB_HZ 32768
`define WTBM_TB_DIV (`WTBM_CLK_HZ / `WTBM_TB_HZ)
`define WTBM_UNIT_SHIFT 5
`define WTBM_SLEEP_SAMPLE_MS 1000
`define WTBM_SLEEP_TICKS (`WTBM_SLEEP_SAMPLE_MS * `WTBM_TB_HZ / 1000)
`endif

// ### verilog/wtbm_prescale.v
`include "wtbm_map.vh"

// Divides the system clock down to a one-cycle timebase enable.
module wtbm_prescale
#(
   parameter DIV = `WTBM_TB_DIV
)
(
   // Clock and reset
   input wire sys_clk,
   input wire reset_n,
   // Timebase enable
   output reg tick
);

   reg [15:0] cnt_reg;

   always @(posedge sys_clk)
   begin
      if (!reset_n)
      begin
         cnt_reg <= 16'h0000;
         tick <= 1'h0;
      end
      else if (cnt_reg == DIV[15:0] - 16'h0001)
      begin
         cnt_reg <= 16'h0000;
         tick <= 1'h1;
      end
      else
      begin
         cnt_reg <= cnt_reg + 16'h0001;
         tick <= 1'h0;
      end
   end

endmodule

// ### testbench/wtbm_top_chk.sv
module wtbm_top_chk (
   // Clock and reset
   input wire sys_clk,
   input wire reset_n,
   // Register port
   input wire [6:0] reg_addr,
   input wire reg_we,
   input wire [7:0] reg_wdata,
   input wire [7:0] reg_rdata,
   // Pins and outputs
   input wire sleep_mode,
   input wire [4:0] supply_code_pin,
   input wire wakeup_event,
   input wire low_duty_on_duration,
   input wire low_battery_irq
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!reset_n);
   a_event_gap:
      assert property (wakeup_event |=> !wakeup_event [*8])
      else $error("Wake event repeated too soon.");
   a_rsvd_zero:
      assert property ($past(reg_addr) inside {7'h1a, 7'h1b}
         |-> reg_rdata[7:5] == 3'h0) else $error("Reserved bits set.");
   a_unmapped_zero:
      assert property (!($past(reg_addr) inside {[7'h14:7'h1b]})
         |-> reg_rdata == 8'h00) else $error("Unmapped read not zero.");
   a_exp_rsvd:
      assert property ($past(reg_addr) == 7'h14 |-> reg_rdata[7:6] == 2'h0)
      else $error("Exponent reserved bits set.");
   a_rw_back:
      assert property ((reg_we && reg_addr inside {7'h15, 7'h16, 7'h19})
         ##1 (!reg_we && $stable(reg_addr))
         |=> reg_rdata == $past(reg_wdata, 2)) else $error("Readback lost.");
   a_thr_back:
      assert property ((reg_we && reg_addr == 7'h1a) ##1
         (!reg_we && reg_addr == 7'h1a) |=> reg_rdata ==
         ($past(reg_wdata, 2) & 8'h1f)) else $error("Threshold readback.");
   a_duty_start:
      assert property ($rose(low_duty_on_duration)
         |-> wakeup_event || $past(wakeup_event))
      else $error("Stray on-time.");
   a_irq_steady:
      assert property ((!sleep_mode && !reg_we && $stable(supply_code_pin))
         [*8] |=> $stable(low_battery_irq)) else $error("Irq moved alone.");
endmodule

// ### testbench/wtbm_top_tb_top.sv
module wtbm_top_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam DIV = 4;
   reg sys_clk = 1'b0;
   reg reset_n = 1'b0;
   reg [6:0] reg_addr = 7'h00;
   reg reg_we = 1'b0;
   reg [7:0] reg_wdata = 8'h00;
   reg sleep_mode = 1'b0;
   reg [4:0] supply_code_pin = 5'h09;
   wire [7:0] reg_rdata;
   wire wakeup_event, low_duty_on_duration, low_battery_irq;
   integer err_count = 0;
   integer checks_done = 0;
   always #4 sys_clk = ~sys_clk;
   wtbm_top #(.TB_DIV(DIV), .SLEEP_TICKS(8)) wtbm_top_inst (
      .sys_clk(sys_clk), .reset_n(reset_n), .reg_addr(reg_addr),
      .reg_we(reg_we), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .sleep_mode(sleep_mode), .supply_code_pin(supply_code_pin),
      .wakeup_event(wakeup_event), .low_battery_irq(low_battery_irq),
      .low_duty_on_duration(low_duty_on_duration));
   task chk(input [15:0] seen, input [15:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         err_count++;
         $display("FAIL %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task results;
      $display("checks %0d mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task rst;
      @(negedge sys_clk) reset_n = 1'b0;
      repeat (16) @(negedge sys_clk);
      reset_n = 1'b1;
   endtask
   task wr(input [6:0] a, input [7:0] d);
      @(negedge sys_clk) reg_addr = a;
      reg_wdata = d;
      reg_we = 1'b1;
      @(negedge sys_clk) reg_we = 1'b0;
   endtask
   task rd(input [6:0] a, input [7:0] e);
      @(negedge sys_clk) reg_addr = a;
      @(negedge sys_clk) chk(reg_rdata, e);
   endtask
   task wait_ev;
      integer i;
      i = 0;
      do
      begin
         @(negedge sys_clk);
         i++;
      end
      while (wakeup_event !== 1'b1 && i < 3000);
      if (i >= 3000)
      begin
         err_count++;
         results;
      end
   endtask
   // The next event cycle is left out of the on-time sum, so the count is
   // right whether on-time starts with the event or one cycle later.
   task per(input integer p, input integer h);
      integer n, hi;
      wait_ev;
      n = 0;
      hi = low_duty_on_duration;
      do
      begin
         @(negedge sys_clk);
         n++;
         if (!wakeup_event)
            hi += low_duty_on_duration;
      end
      while (wakeup_event !== 1'b1 && n < 3000);
      if (n >= 3000)
      begin
         err_count++;
         results;
      end
      chk(n, p);
      chk(hi, h);
   endtask
   task t_reset;
      rd(7'h14, 8'h00);
      rd(7'h15, 8'h00);
      rd(7'h17, 8'h00);
      rd(7'h1a, 8'h14);
      rd(7'h1b, 8'h09);
      rd(7'h00, 8'h00);
      chk(low_battery_irq, 1'b1);
      $display("reset values done");
   endtask
   task t_regs;
      wr(7'h17, 8'h55);
      rd(7'h17, 8'h00);
      wr(7'h14, 8'hff);
      rd(7'h14, 8'h3f);
      wr(7'h15, 8'ha5);
      wr(7'h16, 8'h3c);
      rd(7'h15, 8'ha5);
      rd(7'h16, 8'h3c);
      wr(7'h19, 8'h5a);
      rd(7'h19, 8'h5a);
      wr(7'h1a, 8'hff);
      rd(7'h1a, 8'h1f);
      wr(7'h1b, 8'h00);
      rd(7'h1b, 8'h09);
      $display("register access done");
   endtask
   task t_timer;
      wr(7'h16, 8'h01);
      per(32 * DIV, 0);
      rd(7'h18, 8'h01);
      wr(7'h14, 8'h11);
      wr(7'h16, 8'h02);
      wr(7'h19, 8'h01);
      wait_ev;
      per(128 * DIV, 64 * DIV);
      $display("wake-up timer done");
   endtask
   task t_batt;
      @(negedge sys_clk) sleep_mode = 1'b1;
      supply_code_pin = 5'h18;
      repeat (10) @(negedge sys_clk);
      chk(low_battery_irq, 1'b1);
      rd(7'h1b, 8'h09);
      repeat (40) @(negedge sys_clk);
      chk(low_battery_irq, 1'b0);
      rd(7'h1b, 8'h18);
      sleep_mode = 1'b0;
      supply_code_pin = 5'h13;
      repeat (8) @(negedge sys_clk);
      chk(low_battery_irq, 1'b1);
      supply_code_pin = 5'h14;
      repeat (8) @(negedge sys_clk);
      chk(low_battery_irq, 1'b0);
      $display("battery monitor done");
   endtask
   initial
   begin
      rst;
      t_reset;
      t_regs;
      rst;
      t_timer;
      t_batt;
      results;
   end
endmodule
bind wtbm_top wtbm_top_chk wtbm_top_chk_inst (
   .sys_clk(sys_clk), .reset_n(reset_n), .reg_addr(reg_addr),
   .reg_we(reg_we), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
   .sleep_mode(sleep_mode), .supply_code_pin(supply_code_pin),
   .wakeup_event(wakeup_event), .low_battery_irq(low_battery_irq),
   .low_duty_on_duration(low_duty_on_duration));
